// *** inc/sdio_regs_params.svh ***
`ifndef SDIO_REGS_PARAMS_SVH
`define SDIO_REGS_PARAMS_SVH

// Register byte offsets, one aligned word each
`define OFS_SDIO_CTRL 8'h00
`define OFS_LINE_STATUS 8'h04
`define OFS_IRQ_ENABLE 8'h08
`define OFS_IRQ_FLAGS 8'h0C
`define OFS_FIFO_SETUP 8'h10
`define OFS_FIFO_DATA 8'h14
`define OFS_FIFO_STATUS 8'h18

// Read wait control fields
`define CTRL_RW_REQ_BIT 0
`define CTRL_RW_CRC_BIT 1

// Line status fields
`define ST_LINE1_BIT 0
`define ST_PERIOD_BIT 1
`define ST_RW_ACTIVE_BIT 2

// Enable and flag fields share positions
`define IRQ_CARD_BIT 0
`define IRQ_RW_BIT 1

// Buffer setup fields
`define FS_RESET_BIT 0
`define FS_DIR_BIT 1
`define FS_LEVEL_BIT 2
`define FS_WIDTH_LSB 3
`define FS_WIDTH_MSB 4

// Reset values
`define RST_CTRL 2'h0
`define RST_IRQ_ENABLE 2'h0
`define RST_IRQ_FLAGS 2'h0
`define RST_FIFO_SETUP 5'h00
`define RST_LINE1 1'b1

// Timing and thresholds
`define RW_START_CLKS 2'd2
`define DMA_THR_LOW 9'd128
`define DMA_THR_HIGH 9'd256

// Bus answers
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// *** inc/sdio_regs_pkg.sv ***
package sdio_regs_pkg;

    // Read wait sequencer states
    typedef enum logic [1:0] {
        RW_IDLE,
        RW_ARMED,
        RW_DELAY,
        RW_ACTIVE
    } rw_state_t;

    typedef logic [15:0] reg16_t;

endpackage

// *** inc/stream_if.sv ***
`timescale 1ns/1ps

// Word stream with valid/ready handshake
interface stream_if #(
    parameter int WIDTH = 32
);
    logic [WIDTH-1:0] data;
    logic valid;
    logic ready;

    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface

// *** core/bit_sync.sv ***
`timescale 1ns/1ps

// Two-stage synchroniser for one pin
module bit_sync #(
    parameter logic INIT = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    logic meta;

    // First stage feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= INIT;
            q <= INIT;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// *** core/word_fifo.sv ***
`timescale 1ns/1ps

// Synchronous FIFO, depth a power of two
module word_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    stream_if.snk fill,
    stream_if.src drain,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    localparam int LW = AW + 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic full;
    logic empty;

    // Flags are registered so the ready seen outside is clean
    wire push = fill.valid & ~full;
    wire pop = drain.ready & ~empty;
    wire [LW-1:0] next_level = level + LW'(push) - LW'(pop);

    assign fill.ready = ~full;
    assign drain.valid = ~empty;
    assign drain.data = mem[rd_ptr];

    // Pointer and flag update; flush wins over traffic
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
            full <= 1'b0;
            empty <= 1'b1;
        end else if (flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
            full <= 1'b0;
            empty <= 1'b1;
        end else begin
            wr_ptr <= push ? AW'(wr_ptr + 1'b1) : wr_ptr;
            rd_ptr <= pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
            level <= next_level;
            full <= next_level == LW'(DEPTH);
            empty <= next_level == '0;
        end
    end

    // Storage carries no reset
    always_ff @(posedge clk) begin
        if (push && !flush) begin
            mem[wr_ptr] <= fill.data;
        end
    end
endmodule

// *** core/sdio_irq_fifo_ctrl_regs.sv ***
`timescale 1ns/1ps
`include "sdio_regs_params.svh"

module sdio_irq_fifo_ctrl_regs #(
    parameter int ADDR_W = 8,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic card_clk_pin,
    input wire logic card_data_line_one_pin,
    output logic card_line2_out,
    output logic card_line2_oe,
    input wire logic xfer_active,
    input wire logic blk_end,
    input wire logic crc_err,
    input wire logic multi_blk,
    input wire logic last_blk,
    input wire logic [31:0] card_in_data,
    input wire logic card_in_valid,
    output logic card_in_ready,
    output logic [31:0] card_out_data,
    output logic card_out_valid,
    input wire logic card_out_ready,
    output logic dma_req,
    output logic sdio_irq
);
    localparam int LW = $clog2(FIFO_DEPTH) + 1;

    // Word address match, byte lanes ignored
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        hit = a[ADDR_W-1:2] == ofs[ADDR_W-1:2];
    endfunction

    // Byte-lane merge of a 16-bit register
    function automatic sdio_regs_pkg::reg16_t merge16(input sdio_regs_pkg::reg16_t old,
            input logic [15:0] d, input logic [1:0] strb);
        merge16 = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
    endfunction

    // Bits moved by one host access
    function automatic logic [8:0] access_bits(input logic [1:0] width);
        case (width)
            2'd0: access_bits = 9'd32;
            2'd1: access_bits = 9'd24;
            2'd2: access_bits = 9'd16;
            default: access_bits = 9'd8;
        endcase
    endfunction

    sdio_regs_pkg::rw_state_t rw_state;
    sdio_regs_pkg::rw_state_t next_rw_state;
    logic [1:0] rw_cnt;
    logic [1:0] next_rw_cnt;
    logic rw_req;
    logic rw_crc;
    logic [1:0] irq_en;
    logic [1:0] irq_flags;
    logic [1:0] acc_width;
    logic dma_level;
    logic buf_dir;
    logic buf_reset;
    logic card_clk_s;
    logic card_clk_prev;
    logic line1_s;
    logic line1_last;
    logic period_flag;
    logic [8:0] bit_acc;
    logic aw_full;
    logic w_full;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [LW-1:0] fifo_level;

    stream_if #(.WIDTH(32)) fill ();
    stream_if #(.WIDTH(32)) drain ();

    // Link clock and data line one cross into clk here
    bit_sync #(.INIT(1'b0)) u_clk_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(card_clk_pin),
        .q(card_clk_s)
    );
    bit_sync #(.INIT(`RST_LINE1)) u_line1_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(card_data_line_one_pin),
        .q(line1_s)
    );

    // Card clock edge and interrupt detection
    wire card_edge = card_clk_s & ~card_clk_prev;
    wire rw_active = rw_state == sdio_regs_pkg::RW_ACTIVE;
    wire card_period = ~xfer_active | rw_active;
    wire card_irq_det = card_edge & card_period & line1_last & ~line1_s;

    // Write channel decode; a data write in the card-write direction waits while the buffer is full
    wire aw_hs = awvalid & awready;
    wire w_hs = wvalid & wready;
    wire wsel_ctrl = hit(aw_addr, ADDR_W'(`OFS_SDIO_CTRL));
    wire wsel_en = hit(aw_addr, ADDR_W'(`OFS_IRQ_ENABLE));
    wire wsel_flags = hit(aw_addr, ADDR_W'(`OFS_IRQ_FLAGS));
    wire wsel_setup = hit(aw_addr, ADDR_W'(`OFS_FIFO_SETUP));
    wire wsel_data = hit(aw_addr, ADDR_W'(`OFS_FIFO_DATA));
    wire wsel_ro = hit(aw_addr, ADDR_W'(`OFS_LINE_STATUS))
        | hit(aw_addr, ADDR_W'(`OFS_FIFO_STATUS));
    wire wr_mapped = wsel_ctrl | wsel_en | wsel_flags | wsel_setup | wsel_data | wsel_ro;
    wire wr_stall = wsel_data & buf_dir & ~fill.ready & ~buf_reset;
    wire do_write = aw_full & w_full & ~bvalid & ~wr_stall;
    wire next_aw_full = do_write ? 1'b0 : (aw_full | aw_hs);
    wire next_w_full = do_write ? 1'b0 : (w_full | w_hs);
    wire next_bvalid = do_write | (bvalid & ~bready);

    // Read channel decode
    wire ar_hs = arvalid & arready;
    wire rsel_ctrl = hit(araddr, ADDR_W'(`OFS_SDIO_CTRL));
    wire rsel_stat = hit(araddr, ADDR_W'(`OFS_LINE_STATUS));
    wire rsel_en = hit(araddr, ADDR_W'(`OFS_IRQ_ENABLE));
    wire rsel_flags = hit(araddr, ADDR_W'(`OFS_IRQ_FLAGS));
    wire rsel_setup = hit(araddr, ADDR_W'(`OFS_FIFO_SETUP));
    wire rsel_data = hit(araddr, ADDR_W'(`OFS_FIFO_DATA));
    wire rsel_fstat = hit(araddr, ADDR_W'(`OFS_FIFO_STATUS));
    wire rd_mapped = rsel_ctrl | rsel_stat | rsel_en | rsel_flags | rsel_setup | rsel_data
        | rsel_fstat;
    wire next_rvalid = ar_hs | (rvalid & ~rready);

    // Register views, upper bits read as zero
    wire [15:0] ctrl_view = {14'h0000, rw_crc, rw_req};
    wire [15:0] stat_view = {13'h0000, rw_active, period_flag, line1_s};
    wire [15:0] en_view = {14'h0000, irq_en};
    wire [15:0] flags_view = {14'h0000, irq_flags};
    wire [15:0] setup_view = {11'h000, acc_width, dma_level, buf_dir, buf_reset};
    wire [15:0] fstat_view = {14'h0000, ~drain.valid, ~fill.ready} | 16'(fifo_level) << 2;
    wire [15:0] ctrl_wr = merge16(ctrl_view, w_data[15:0], w_strb[1:0]);
    wire [15:0] en_wr = merge16(en_view, w_data[15:0], w_strb[1:0]);
    wire [15:0] setup_wr = merge16(setup_view, w_data[15:0], w_strb[1:0]);
    wire [31:0] rd_word = rsel_ctrl ? {16'h0000, ctrl_view}
        : rsel_stat ? {16'h0000, stat_view}
        : rsel_en ? {16'h0000, en_view}
        : rsel_flags ? {16'h0000, flags_view}
        : rsel_setup ? {16'h0000, setup_view}
        : (rsel_data && drain.valid && !buf_dir) ? drain.data
        : rsel_fstat ? {16'h0000, fstat_view}
        : 32'h0000_0000;

    // Buffer steering by direction
    wire host_push = do_write & wsel_data & buf_dir & ~buf_reset;
    wire host_pop = ar_hs & rsel_data & ~buf_dir & drain.valid & ~buf_reset;
    assign fill.valid = buf_dir ? host_push : card_in_valid;
    assign fill.data = buf_dir ? w_data : card_in_data;
    assign drain.ready = buf_dir ? card_out_ready : host_pop;
    assign card_in_ready = fill.ready & ~buf_dir & ~buf_reset;
    assign card_out_valid = drain.valid & buf_dir & ~buf_reset;
    assign card_out_data = drain.data;

    word_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .flush(buf_reset),
        .fill(fill),
        .drain(drain),
        .level(fifo_level)
    );

    // Host-side accounting of bits for DMA requests
    wire host_xfer = buf_dir ? host_push : host_pop;
    wire [8:0] dma_thr = dma_level ? `DMA_THR_HIGH : `DMA_THR_LOW;
    wire [8:0] next_bits = bit_acc + access_bits(acc_width);
    wire thr_hit = next_bits >= dma_thr;

    // Auto request on a CRC error ahead of the final block
    wire crc_trigger = rw_crc & crc_err & multi_blk & ~last_blk;
    wire req_now = rw_req | crc_trigger;
    wire rw_start = (next_rw_state == sdio_regs_pkg::RW_ACTIVE) & ~rw_active;
    wire [1:0] flag_set = {rw_start & irq_en[`IRQ_RW_BIT],
        card_irq_det & irq_en[`IRQ_CARD_BIT]};
    wire [1:0] flag_clr = (do_write && wsel_flags && w_strb[0]) ? w_data[1:0] : 2'b00;
    wire [1:0] next_flags = (irq_flags & ~flag_clr) | flag_set;

    // Read wait sequencer; a dropped request ends it from any state
    always_comb begin
        next_rw_state = rw_state;
        next_rw_cnt = rw_cnt;
        case (rw_state)
            sdio_regs_pkg::RW_IDLE: begin
                if (req_now) begin
                    next_rw_state = blk_end ? sdio_regs_pkg::RW_DELAY : sdio_regs_pkg::RW_ARMED;
                    next_rw_cnt = 2'd0;
                end
            end
            sdio_regs_pkg::RW_ARMED: begin
                if (blk_end) begin
                    next_rw_state = sdio_regs_pkg::RW_DELAY;
                    next_rw_cnt = 2'd0;
                end
            end
            sdio_regs_pkg::RW_DELAY: begin
                if (card_edge) begin
                    if (rw_cnt == `RW_START_CLKS - 2'd1) begin
                        next_rw_state = sdio_regs_pkg::RW_ACTIVE;
                    end else begin
                        next_rw_cnt = rw_cnt + 2'd1;
                    end
                end
            end
            sdio_regs_pkg::RW_ACTIVE: begin
                next_rw_state = sdio_regs_pkg::RW_ACTIVE;
            end
            default: begin
                next_rw_state = sdio_regs_pkg::RW_IDLE;
            end
        endcase
        if (!req_now) begin
            next_rw_state = sdio_regs_pkg::RW_IDLE;
        end
    end

    // Link sampling and sequencer state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            card_clk_prev <= 1'b0;
            line1_last <= `RST_LINE1;
            rw_state <= sdio_regs_pkg::RW_IDLE;
            rw_cnt <= 2'd0;
            period_flag <= 1'b0;
        end else begin
            card_clk_prev <= card_clk_s;
            line1_last <= card_edge ? line1_s : line1_last;
            rw_state <= next_rw_state;
            rw_cnt <= next_rw_cnt;
            period_flag <= card_period;
        end
    end

    // Pins and interrupt, all registered
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            card_line2_out <= 1'b0;
            card_line2_oe <= 1'b0;
            sdio_irq <= 1'b0;
        end else begin
            card_line2_out <= 1'b0;
            card_line2_oe <= next_rw_state == sdio_regs_pkg::RW_ACTIVE;
            sdio_irq <= |next_flags;
        end
    end

    // Software registers; hardware set beats a same-cycle write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {rw_crc, rw_req} <= `RST_CTRL;
            irq_en <= `RST_IRQ_ENABLE;
            irq_flags <= `RST_IRQ_FLAGS;
            {acc_width, dma_level, buf_dir, buf_reset} <= `RST_FIFO_SETUP;
        end else begin
            irq_flags <= next_flags;
            if (do_write && wsel_ctrl) begin
                rw_crc <= ctrl_wr[`CTRL_RW_CRC_BIT];
            end
            if (crc_trigger) begin
                rw_req <= 1'b1;
            end else if (do_write && wsel_ctrl) begin
                rw_req <= ctrl_wr[`CTRL_RW_REQ_BIT];
            end
            if (do_write && wsel_en) begin
                irq_en <= en_wr[1:0];
            end
            if (do_write && wsel_setup) begin
                acc_width <= setup_wr[`FS_WIDTH_MSB:`FS_WIDTH_LSB];
                dma_level <= setup_wr[`FS_LEVEL_BIT];
                buf_dir <= setup_wr[`FS_DIR_BIT];
                buf_reset <= setup_wr[`FS_RESET_BIT];
            end
        end
    end

    // DMA request pulse each time the threshold of bits is passed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_acc <= 9'd0;
            dma_req <= 1'b0;
        end else if (buf_reset) begin
            bit_acc <= 9'd0;
            dma_req <= 1'b0;
        end else begin
            dma_req <= host_xfer & thr_hit;
            if (host_xfer) begin
                bit_acc <= thr_hit ? next_bits - dma_thr : next_bits;
            end
        end
    end

    // Write channel: address and data taken in either order
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
        end else begin
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            aw_addr <= aw_hs ? awaddr : aw_addr;
            w_data <= w_hs ? wdata : w_data;
            w_strb <= w_hs ? wstrb : w_strb;
            awready <= ~next_aw_full;
            wready <= ~next_w_full;
            bvalid <= next_bvalid;
            bresp <= do_write ? (wr_mapped ? `RESP_OKAY : `RESP_SLVERR) : bresp;
        end
    end

    // Read channel: one read in flight, answer registered
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `RESP_OKAY;
        end else begin
            arready <= ~next_rvalid;
            rvalid <= next_rvalid;
            if (ar_hs) begin
                rdata <= rd_word;
                rresp <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
            end
        end
    end
endmodule

// *** bench/sdio_regs_properties.sv ***
`timescale 1ns/1ps

// Port-level checks on the bus, line two, the stream sides and the interrupt
module sdio_regs_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic card_line2_out,
    input wire logic card_line2_oe,
    input wire logic card_in_ready,
    input wire logic card_out_valid,
    input wire logic dma_req,
    input wire logic sdio_irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Answers come in bounded time and stand until taken
    write_answer_a: assert property (awvalid && awready && wvalid && wready |=>
        !awready && !wready ##[1:64] bvalid) else $error("write not answered");
    bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    read_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read not answered");
    rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    // Line two is only pulled low, and only a register write lets it go
    line2_low_a: assert property (card_line2_oe |-> !card_line2_out)
        else $error("line two driven high");
    line2_release_a: assert property ($fell(card_line2_oe) |-> $past(bvalid))
        else $error("line two released without a write");
    // Flag and bvalid update on the same edge, so the answer stands when the drop is seen
    irq_release_a: assert property ($fell(sdio_irq) |-> bvalid)
        else $error("interrupt dropped without a clear");
    dma_pulse_a: assert property (dma_req |=> !dma_req)
        else $error("dma request too long");
    stream_dir_a: assert property (card_in_ready |-> !card_out_valid)
        else $error("both stream sides open");

    // Main scenarios reached
    cover property (bvalid && bready);
    cover property ($rose(card_line2_oe));
    cover property ($rose(sdio_irq));
    cover property (dma_req);
endmodule

bind sdio_irq_fifo_ctrl_regs sdio_regs_checker u_sdio_regs_checker (.*);

// *** bench/card_model.sv ***
`timescale 1ns/1ps

// Card side: link clock, line one, words in and words out
module card_model (
    input wire logic clk,
    input wire logic run,
    input wire logic line1_low,
    input wire logic send,
    input wire logic stall,
    output logic card_clk_pin,
    output logic card_data_line_one_pin,
    output logic [31:0] card_in_data,
    output logic card_in_valid,
    input wire logic card_in_ready,
    input wire logic [31:0] card_out_data,
    input wire logic card_out_valid,
    output logic card_out_ready,
    output logic [31:0] rx_sum
);
    logic [31:0] seq = 32'h0000_0100;
    logic offer = 1'h0;
    logic [31:0] sum = 32'h0000_0000;

    // Link clock parks low between frames; odd offset keeps it off system edges
    initial begin
        card_clk_pin = 1'h0;
        #13.3;
        forever #40 card_clk_pin = run ? ~card_clk_pin : 1'h0;
    end

    // Pulled-up line reads high when released; idle bus never repeats a word
    assign card_data_line_one_pin = ~line1_low;
    assign card_in_data = card_in_valid ? seq : ~seq;
    assign card_out_ready = ~stall;
    assign card_in_valid = offer;
    assign rx_sum = sum;

    // Offered word stays up until taken; accepted words are summed
    always @(posedge clk) begin
        offer <= send | (offer & ~card_in_ready);
        if (offer && card_in_ready) begin
            seq <= seq + 32'h0000_0001;
        end
        if (card_out_valid && card_out_ready) begin
            sum <= sum + card_out_data;
        end
    end
endmodule

// *** bench/testbench.sv ***
`timescale 1ns/1ps

// Register, read wait, card interrupt and buffer checks at the ports
module testbench;
    typedef struct packed {
        logic [7:0] a;
        logic [15:0] d;
        logic [15:0] e;
        logic w;
    } row_t;

    logic clk = 1'h0, rst_n = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0, xfer_active = 1'h1, blk_end = 1'h0;
    logic crc_err = 1'h0, multi_blk = 1'h0, last_blk = 1'h0;
    logic run = 1'h0, line1_low = 1'h0, send = 1'h0, stall = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, card_line2_out, card_line2_oe;
    logic card_in_ready, card_in_valid, card_out_valid, card_out_ready, dma_req;
    logic sdio_irq, card_clk_pin, card_data_line_one_pin;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, card_in_data, card_out_data, rx_sum, v;
    int err_count = 0, checked = 0, dma_cnt = 0, i, n;

    // Reset reads first, then writes with their read-back
    row_t rows [10] = '{
        '{8'h00, 16'h0000, 16'h0000, 1'h0}, '{8'h04, 16'h0000, 16'h0001, 1'h0},
        '{8'h08, 16'h0000, 16'h0000, 1'h0}, '{8'h0c, 16'h0000, 16'h0000, 1'h0},
        '{8'h10, 16'h0000, 16'h0000, 1'h0}, '{8'h08, 16'hfffe, 16'h0002, 1'h1},
        '{8'h10, 16'h001e, 16'h001e, 1'h1}, '{8'h00, 16'h0002, 16'h0002, 1'h1},
        '{8'h04, 16'hffff, 16'h0001, 1'h1}, '{8'h0c, 16'h0003, 16'h0000, 1'h1}
    };

    sdio_irq_fifo_ctrl_regs u_sdio_irq_fifo_ctrl_regs (.*);
    card_model u_card_model (.*);

    // Clock and a count of request pulses
    always #2 clk = ~clk;
    always @(posedge clk) if (dma_req === 1'h1) dma_cnt <= dma_cnt + 1;

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // A used-up wait counts as a mismatch and ends the run
    task automatic bound(input int k);
        if (k >= 300) begin
            err_count++;
            $display("wrong value at %0t: wait ran out", $time);
            finish_test();
        end
    endtask

    task automatic tick(input int c);
        repeat (c) @(posedge clk);
    endtask

    // Both write channels offered together; ready raised late to test holding
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        do begin
            @(posedge clk);
            k++;
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid && !bready) bready <= 1'h1;
        end while (!(bvalid && bready) && k < 300);
        bready <= 1'h0;
        r = bresp;
        bound(k);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        int k;
        k = 0;
        araddr <= a;
        arvalid <= 1'h1;
        do begin
            @(posedge clk);
            k++;
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid && !rready) rready <= 1'h1;
        end while (!(rvalid && rready) && k < 300);
        rready <= 1'h0;
        v = rdata;
        r = rresp;
        bound(k);
        chk(v, e);
    endtask

    initial begin
        tick(6);
        rst_n <= 1'h1;
        tick(2);
        for (i = 0; i < 10; i++) begin
            if (rows[i].w) wr(rows[i].a, {16'h0000, rows[i].d});
            rc(rows[i].a, {16'h0000, rows[i].e});
        end
        // Unmapped place: error answer, no data
        wr(8'h40, 32'h0000_0001);
        chk(32'(r), 32'h0000_0002);
        rc(8'h40, 32'h0000_0000);
        chk(32'(r), 32'h0000_0002);
        // Card interrupt period: masked, then recorded and cleared
        xfer_active <= 1'h0;
        run <= 1'h1;
        line1_low <= 1'h1;
        tick(100);
        rc(8'h04, 32'h0000_0002);
        rc(8'h0c, 32'h0000_0000);
        line1_low <= 1'h0;
        wr(8'h08, 32'h0000_0003);
        tick(40);
        line1_low <= 1'h1;
        for (n = 0; n < 300 && sdio_irq !== 1'h1; n++) @(posedge clk);
        bound(n);
        rc(8'h0c, 32'h0000_0001);
        line1_low <= 1'h0;
        wr(8'h0c, 32'h0000_0001);
        rc(8'h0c, 32'h0000_0000);
        chk(32'(sdio_irq), 32'h0000_0000);
        xfer_active <= 1'h1;
        // Read wait by request waits for the block end
        wr(8'h00, 32'h0000_0001);
        tick(60);
        chk(32'(card_line2_oe), 32'h0000_0000);
        blk_end <= 1'h1;
        tick(1);
        blk_end <= 1'h0;
        for (n = 0; n < 300 && card_line2_oe !== 1'h1; n++) @(posedge clk);
        bound(n);
        rc(8'h04, 32'h0000_0007);
        rc(8'h0c, 32'h0000_0002);
        chk(32'(sdio_irq), 32'h0000_0001);
        wr(8'h0c, 32'h0000_0000);
        rc(8'h0c, 32'h0000_0002);
        wr(8'h00, 32'h0000_0000);
        tick(2);
        chk(32'(card_line2_oe), 32'h0000_0000);
        rc(8'h04, 32'h0000_0001);
        wr(8'h0c, 32'h0000_0002);
        tick(2);
        chk(32'(sdio_irq), 32'h0000_0000);
        // CRC error mid-way through a multi-block read
        wr(8'h00, 32'h0000_0002);
        // A CRC error on the final block leaves read wait alone
        multi_blk <= 1'h1;
        last_blk <= 1'h1;
        crc_err <= 1'h1;
        tick(1);
        crc_err <= 1'h0;
        last_blk <= 1'h0;
        rc(8'h00, 32'h0000_0002);
        chk(32'(card_line2_oe), 32'h0000_0000);
        multi_blk <= 1'h1;
        crc_err <= 1'h1;
        tick(1);
        crc_err <= 1'h0;
        blk_end <= 1'h1;
        tick(1);
        blk_end <= 1'h0;
        for (n = 0; n < 300 && card_line2_oe !== 1'h1; n++) @(posedge clk);
        bound(n);
        rc(8'h00, 32'h0000_0003);
        wr(8'h00, 32'h0000_0000);
        multi_blk <= 1'h0;
        run <= 1'h0;
        // Card write: fill while the card stalls, then drain
        stall <= 1'h1;
        wr(8'h10, 32'h0000_0006);
        for (i = 0; i < 8; i++) wr(8'h14, 32'h1111_0000 + 32'(i));
        rc(8'h18, 32'h0000_0021);
        chk(32'(dma_cnt), 32'h0000_0001);
        stall <= 1'h0;
        for (n = 0; n < 300 && card_out_valid !== 1'h0; n++) @(posedge clk);
        bound(n);
        chk(rx_sum, 32'h8888_001c);
        // Card read at three-byte accounting, then buffer reset
        wr(8'h10, 32'h0000_0008);
        send <= 1'h1;
        for (n = 0; n < 300 && card_in_ready !== 1'h0; n++) @(posedge clk);
        bound(n);
        send <= 1'h0;
        for (i = 0; i < 8; i++) rc(8'h14, 32'h0000_0100 + 32'(i));
        chk(32'(dma_cnt), 32'h0000_0002);
        wr(8'h10, 32'h0000_0009);
        rc(8'h18, 32'h0000_0002);
        chk(32'(card_in_ready), 32'h0000_0000);
        wr(8'h10, 32'h0000_0002);
        rc(8'h18, 32'h0000_0002);
        finish_test();
    end
endmodule
